// File: hw/adc_port_pkg.sv
// Purpose: shared constants for the four-channel simultaneous read port
// Assumes: 100 MHz system clock, conversion clock sampled as a pin input
// Notes:   conversion timing is counted in conversion-clock rising edges
package adc_port_pkg;

  // ----------------------------------------------------------------
  // data and channel layout
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_W     = 12;
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned CH_W         = 2;
  localparam int unsigned RESULT_MSB   = 11;
  localparam int unsigned RESULT_LSB   = 0;
  localparam logic [1:0]  CH_FIRST     = 2'h0;
  localparam logic [1:0]  CH_LAST      = 2'h3;

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  // edges for one channel; four channels plus two closing edges give 78
  localparam int unsigned EDGES_PER_CH = 19;
  localparam int unsigned SEQ_EDGES    = 78;
  localparam int unsigned EDGE_CNT_W   = 7;
  localparam logic [6:0]  EDGE_LAST    = 7'h4D;  // 78 - 1
  localparam logic [6:0]  EDGE_ZERO    = 7'h00;

  // internal oscillator: period in ns and half-period in CLK cycles
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OSC_PERIOD_NS = 400;
  localparam int unsigned OSC_HALF_CYC  =
    OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned OSC_CNT_W     = 8;

  // external clock considered absent after this many system cycles
  localparam int unsigned EXT_IDLE_NS   = 20000;
  localparam int unsigned EXT_IDLE_CYC  = EXT_IDLE_NS / CLK_PERIOD_NS;
  localparam int unsigned IDLE_CNT_W    = 12;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_TRACK = 3'b001,
    ST_CONV  = 3'b010,
    ST_READY = 3'b100
  } seq_state_t;

endpackage : adc_port_pkg

// File: hw/pin_sync.sv
// Purpose: two-flop synchroniser for one pin input
// Assumes: pin is asynchronous to CLK
// Notes:   first flop feeds only the second flop
`timescale 1ns/100ps
module pin_sync
#(
  parameter logic INIT = 1'b0
)
(
  // clock
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // pin in, synchronised out
  input  wire logic pin,
  output logic      sync
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // next values
  always_comb
  begin
    meta_d = ce ? pin : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  // two-stage register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync = sync_q;

endmodule : pin_sync

// File: hw/conv_clock_sel.sv
// Purpose: choose external conversion clock or internal oscillator
// Assumes: synchronised clock pin level as input
// Notes:   a pin held low long enough counts as tied to negative supply
`timescale 1ns/100ps
module conv_clock_sel
#(
  parameter int unsigned IDLE_CYC = adc_port_pkg::EXT_IDLE_CYC,
  parameter int unsigned HALF_CYC = adc_port_pkg::OSC_HALF_CYC
)
(
  // clock
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // synchronised clock pin
  input  wire logic clk_pin_s,
  // one-cycle pulse per rising conversion-clock edge
  output logic      edge_pulse,
  output logic      use_internal
);

  localparam int unsigned IW = adc_port_pkg::IDLE_CNT_W;
  localparam int unsigned OW = adc_port_pkg::OSC_CNT_W;

  logic          prev_q,  prev_d;
  logic [IW-1:0] idle_q,  idle_d;
  logic          int_q,   int_d;
  logic [OW-1:0] osc_q,   osc_d;
  logic          osc_lv_q, osc_lv_d;
  logic          edge_q,  edge_d;

  // pin watch, oscillator and edge selection
  always_comb
  begin
    prev_d   = clk_pin_s;
    idle_d   = idle_q;
    int_d    = int_q;
    osc_d    = osc_q;
    osc_lv_d = osc_lv_q;
    edge_d   = 1'b0;
    if (clk_pin_s)
    begin
      idle_d = '0;
      int_d  = 1'b0; // external clock present
    end
    else if (idle_q == IW'(IDLE_CYC - 1))
      int_d  = 1'b1; // pin tied low: internal oscillator
    else
      idle_d = idle_q + IW'(1);
    if (osc_q == OW'(HALF_CYC - 1))
    begin
      osc_d    = '0;
      osc_lv_d = ~osc_lv_q;
    end
    else
      osc_d = osc_q + OW'(1);
    if (int_q)
      edge_d = (osc_q == OW'(HALF_CYC - 1)) && !osc_lv_q;
    else
      edge_d = clk_pin_s && !prev_q;
  end

  // register state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_q   <= 1'b0;
      idle_q   <= '0;
      int_q    <= 1'b0;
      osc_q    <= '0;
      osc_lv_q <= 1'b0;
      edge_q   <= 1'b0;
    end
    else if (ce)
    begin
      prev_q   <= prev_d;
      idle_q   <= idle_d;
      int_q    <= int_d;
      osc_q    <= osc_d;
      osc_lv_q <= osc_lv_d;
      edge_q   <= edge_d;
    end
  end

  assign edge_pulse   = edge_q;
  assign use_internal = int_q;

endmodule : conv_clock_sel

// File: hw/quad_adc_read_port.sv
// Purpose: control and read-out of a four-channel simultaneous converter
// Assumes: conversion results arrive as four 12-bit words from the core
// Notes:   data pins are split into value and enable, both registered
//
// Summary of operation
// - a rising trigger edge puts all track/holds in hold and starts.
// - channels are converted in order 1, 2, 3, 4 within a cycle.
// - the trigger is taken at any time, independent of select and read.
// - an active-low completion flag output reports converter status.
// - when the flag falls the track/holds return to track mode.
// - data is enabled onto the bus only while select and read are low.
// - four reads after a conversion return channels 1 to 4 in order.
// - the device is selected only while chip select is held low.
// - conversion runs on the clock pin, or internal oscillator if tied low.
// - each result is a 12-bit two's-complement word, bit 11 the MSB.
// - data outputs are three-state, released whenever no read is on.
// - the flag falls only after all four results are stored.
// - the whole sequence takes 78 or 79 rising conversion-clock edges.
// - no result register can be addressed directly, only in sequence.
`timescale 1ns/100ps
module quad_adc_read_port
#(
  parameter int unsigned DATA_W   = adc_port_pkg::RESULT_W,
  parameter int unsigned IDLE_CYC = adc_port_pkg::EXT_IDLE_CYC,
  parameter int unsigned HALF_CYC = adc_port_pkg::OSC_HALF_CYC
)
(
  // system clock, reset, enable
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CE,
  // control pins from host
  input  wire logic              CONVERSION_TRIGGER,
  input  wire logic              CS_N,
  input  wire logic              RD_N,
  input  wire logic              CONV_CLK,
  // conversion results from the sampling core, one per channel
  input  wire logic [DATA_W-1:0] CH1_SAMPLE,
  input  wire logic [DATA_W-1:0] CH2_SAMPLE,
  input  wire logic [DATA_W-1:0] CH3_SAMPLE,
  input  wire logic [DATA_W-1:0] CH4_SAMPLE,
  // status and track/hold control
  output logic                   INT_N,
  output logic                   HOLD,
  output logic [1:0]             CONV_CH,
  // three-state result bus
  output logic [DATA_W-1:0]      RESULT_BUS_O,
  output logic                   RESULT_BUS_OE
);

  localparam int unsigned CW = adc_port_pkg::CH_W;
  localparam int unsigned EW = adc_port_pkg::EDGE_CNT_W;
  localparam int unsigned NC = adc_port_pkg::NUM_CH;
  localparam int unsigned EPC = adc_port_pkg::EDGES_PER_CH;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic trig_s;
  logic cs_n_s;
  logic rd_n_s;
  logic cclk_s;

  pin_sync #(.INIT(1'b0)) u_sync_trig
  (
    .clk  (CLK),
    .rst  (RST),
    .ce   (CE),
    .pin  (CONVERSION_TRIGGER),
    .sync (trig_s)
  );

  pin_sync #(.INIT(1'b1)) u_sync_cs
  (
    .clk  (CLK),
    .rst  (RST),
    .ce   (CE),
    .pin  (CS_N),
    .sync (cs_n_s)
  );

  pin_sync #(.INIT(1'b1)) u_sync_rd
  (
    .clk  (CLK),
    .rst  (RST),
    .ce   (CE),
    .pin  (RD_N),
    .sync (rd_n_s)
  );

  pin_sync #(.INIT(1'b0)) u_sync_cclk
  (
    .clk  (CLK),
    .rst  (RST),
    .ce   (CE),
    .pin  (CONV_CLK),
    .sync (cclk_s)
  );

  // ----------------------------------------------------------------
  // conversion clock source
  // ----------------------------------------------------------------
  logic cedge;

  conv_clock_sel #(
    .IDLE_CYC (IDLE_CYC),
    .HALF_CYC (HALF_CYC)
  ) u_clk_sel
  (
    .clk          (CLK),
    .rst          (RST),
    .ce           (CE),
    .clk_pin_s    (cclk_s),
    .edge_pulse   (cedge),
    .use_internal ()
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adc_port_pkg::seq_state_t st_q, st_d;
  logic              trig_prev_q, trig_prev_d;
  logic              arm_q,       arm_d;
  logic [EW-1:0]     edges_q,     edges_d;
  logic [CW-1:0]     conv_ch_q,   conv_ch_d;
  logic [CW-1:0]     rd_ptr_q,    rd_ptr_d;
  logic              rd_prev_q,   rd_prev_d;
  logic              int_n_q,     int_n_d;
  logic              hold_q,      hold_d;
  logic [DATA_W-1:0] res_q [NC];
  logic [DATA_W-1:0] res_d [NC];
  logic [DATA_W-1:0] bus_q,       bus_d;
  logic              oe_q,        oe_d;

  logic trig_rise;
  logic read_act;
  logic read_end;
  logic [DATA_W-1:0] sample_sel;

  // trigger edge and read strobe qualification
  always_comb
  begin
    trig_rise = trig_s && !trig_prev_q; // synchronised to CLK, independent of CS, RD
    read_act  = !cs_n_s && !rd_n_s;     // selected only on low CS
    read_end  = rd_prev_q && !read_act;
  end

  // sample source for the channel now being converted
  always_comb
  begin
    unique case (conv_ch_q)
      2'h0:    sample_sel = CH1_SAMPLE;
      2'h1:    sample_sel = CH2_SAMPLE;
      2'h2:    sample_sel = CH3_SAMPLE;
      default: sample_sel = CH4_SAMPLE;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d        = st_q;
    trig_prev_d = trig_s;
    arm_d       = arm_q;
    edges_d     = edges_q;
    conv_ch_d   = conv_ch_q;
    rd_ptr_d    = rd_ptr_q;
    rd_prev_d   = read_act;
    int_n_d     = int_n_q;
    hold_d      = hold_q;
    res_d       = res_q;
    if (trig_rise)
    begin
      st_d      = adc_port_pkg::ST_CONV;
      hold_d    = 1'b1;                    // all channels into hold
      arm_d     = 1'b0;                    // wait for first clock edge
      edges_d   = adc_port_pkg::EDGE_ZERO;
      conv_ch_d = adc_port_pkg::CH_FIRST;  // start at channel 1
      rd_ptr_d  = adc_port_pkg::CH_FIRST;
      int_n_d   = 1'b1;
    end
    else
    begin
      if (read_act)
        int_n_d = 1'b1;                    // read clears ready
      unique case (st_q)
        adc_port_pkg::ST_TRACK:
        begin
          hold_d = 1'b0;
        end
        adc_port_pkg::ST_CONV:
        begin
          if (cedge)
          begin
            // first edge only aligns: gives 78 or 79 edges in all
            if (!arm_q)
              arm_d = 1'b1;
            else
            begin
              edges_d = edges_q + EW'(1);
              if (edges_q == EW'(EPC * (32'(conv_ch_q) + 1) - 1))
              begin
                res_d[conv_ch_q] = sample_sel; // store in order
                if (conv_ch_q != adc_port_pkg::CH_LAST)
                  conv_ch_d = conv_ch_q + CW'(1);
              end
              if (edges_q == adc_port_pkg::EDGE_LAST)
              begin
                // all four stored: flag falls, ST_READY, track/holds back to track
                st_d    = adc_port_pkg::ST_READY;
                int_n_d = 1'b0;    // wins over a read
                hold_d  = 1'b0;
              end
            end
          end
        end
        adc_port_pkg::ST_READY:
        begin
          hold_d = 1'b0;
        end
        default:
        begin
          st_d = adc_port_pkg::ST_TRACK;
        end
      endcase
      if (read_end)
        rd_ptr_d = rd_ptr_q + CW'(1);      // implicit address only
    end
  end

  // ----------------------------------------------------------------
  // read port next state
  // ----------------------------------------------------------------
  always_comb
  begin
    oe_d  = read_act;                      // both strobes low
    bus_d = read_act ? res_q[rd_ptr_q] : '0; // channel order 1..4
  end

  // register all state
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_q        <= adc_port_pkg::ST_TRACK;
      trig_prev_q <= 1'b0;
      arm_q       <= 1'b0;
      edges_q     <= adc_port_pkg::EDGE_ZERO;
      conv_ch_q   <= adc_port_pkg::CH_FIRST;
      rd_ptr_q    <= adc_port_pkg::CH_FIRST;
      rd_prev_q   <= 1'b0;
      int_n_q     <= 1'b1;
      hold_q      <= 1'b0;
      res_q       <= '{default: '0};
      bus_q       <= '0;
      oe_q        <= 1'b0;
    end
    else if (CE)
    begin
      st_q        <= st_d;
      trig_prev_q <= trig_prev_d;
      arm_q       <= arm_d;
      edges_q     <= edges_d;
      conv_ch_q   <= conv_ch_d;
      rd_ptr_q    <= rd_ptr_d;
      rd_prev_q   <= rd_prev_d;
      int_n_q     <= int_n_d;
      hold_q      <= hold_d;
      res_q       <= res_d;
      bus_q       <= bus_d;
      oe_q        <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign INT_N         = int_n_q;
  assign HOLD          = hold_q;
  assign CONV_CH       = conv_ch_q;
  assign RESULT_BUS_O  = bus_q;           // 12-bit two's complement
  assign RESULT_BUS_OE = oe_q;

endmodule : quad_adc_read_port

// File: sim/quad_adc_read_port_asserts.sv
// Purpose: port checks of the four-channel read port
// Assumes: CE high, external conversion clock of 8 CLK
// Notes:   bind at the foot
`timescale 1ns/100ps
module quad_adc_read_port_chk
#(
  parameter int unsigned DATA_W = adc_port_pkg::RESULT_W
)
(
  // clock and reset
  input wire logic              CLK,
  input wire logic              RST,
  // pins
  input wire logic              CONVERSION_TRIGGER,
  input wire logic              CS_N,
  input wire logic              RD_N,
  input wire logic              CONV_CLK,
  // outputs
  input wire logic              INT_N,
  input wire logic              HOLD,
  input wire logic [1:0]        CONV_CH,
  input wire logic [DATA_W-1:0] RESULT_BUS_O,
  input wire logic              RESULT_BUS_OE
);
  // --------------------------------------------------------
  // conversion-clock edges since the trigger
  // --------------------------------------------------------
  logic       cclk_q;
  logic       trig_q;
  logic [7:0] edges_q;
  logic [7:0] edges_d;

  // clear on trigger, count rising edges
  always_comb
  begin
    edges_d = edges_q;
    if (CONVERSION_TRIGGER && !trig_q)
      edges_d = 8'h00;
    else if (CONV_CLK && !cclk_q && edges_q != 8'hFF)
      edges_d = edges_q + 8'h01;
  end

  // registers only
  always_ff @(posedge CLK)
  begin
    cclk_q  <= CONV_CLK;
    trig_q  <= CONVERSION_TRIGGER;
    edges_q <= RST ? 8'h00 : edges_d;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence both_low;
    !CS_N && !RD_N;
  endsequence
  sequence read_held;
    both_low [*4];
  endsequence

  a_oe_needs_strobes: assert property (
    RESULT_BUS_OE |-> $past(!CS_N && !RD_N, 3))
    else $error("bus driven without strobes");
  a_read_drives_bus: assert property (
    read_held |-> RESULT_BUS_OE) else $error("read not answered");
  a_bus_idle_zero: assert property (
    !RESULT_BUS_OE |-> RESULT_BUS_O == '0) else $error("idle bus");
  a_read_clears_flag: assert property (
    $rose(RESULT_BUS_OE) && !$fell(INT_N) |-> INT_N)
    else $error("flag kept low");
  a_hold_on_trigger: assert property (
    $rose(CONVERSION_TRIGGER) |-> ##[2:4] HOLD) else $error("no hold");
  a_hold_first_ch: assert property (
    $rose(HOLD) |-> CONV_CH == 2'h0) else $error("first channel");
  a_ch_steps_up: assert property (
    HOLD && $past(HOLD) && CONV_CH != $past(CONV_CH) |->
    CONV_CH == 2'($past(CONV_CH) + 2'h1) || CONV_CH == 2'h0)
    else $error("channel order");
  a_flag_ends_hold: assert property (
    $fell(INT_N) |-> !HOLD && $past(HOLD)) else $error("hold at end");
  a_conv_edges: assert property (
    $fell(INT_N) && edges_q > 8'h10 |-> edges_q inside {[78:80]})
    else $error("conversion edge count");
endmodule : quad_adc_read_port_chk

bind quad_adc_read_port quad_adc_read_port_chk #(.DATA_W(DATA_W)) chk
(
  .CLK, .RST, .CONVERSION_TRIGGER, .CS_N, .RD_N, .CONV_CLK, .INT_N,
  .HOLD, .CONV_CH, .RESULT_BUS_O, .RESULT_BUS_OE
);

// File: sim/host_reader.sv
// Purpose: host model reading results over the parallel port
// Assumes: one read per go pulse, strobes moved after CLK edges
// Notes:   sel low keeps chip select high, a stray strobe
`timescale 1ns/100ps
module host_reader
(
  // clock and request
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        sel,
  input  wire logic [3:0]  lag,
  // result bus
  input  wire logic [11:0] bus_o,
  input  wire logic        bus_oe,
  // strobes and capture
  output logic             cs_n,
  output logic             rd_n,
  output logic [12:0]      got,
  output logic             got_v,
  output logic             busy
);
  int n;

  // idle strobes high, then one read per request; lag holds strobes longer
  initial
  begin
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    got   = 13'h0000;
    got_v = 1'b0;
    busy  = 1'b0;
    forever
    begin
      @(posedge clk);
      if (go === 1'b1)
      begin
        busy <= 1'b1;
        cs_n <= ~sel;  // both low together when sel is high
        rd_n <= 1'b0;
        @(posedge clk);
        for (n = 0; n < 9 && bus_oe !== 1'b1; n++)
          @(posedge clk);
        repeat (lag) @(posedge clk);
        got   <= {bus_oe, bus_o};
        got_v <= 1'b1;
        cs_n  <= 1'b1;
        rd_n  <= 1'b1;
        @(posedge clk);
        got_v <= 1'b0;
        repeat (4) @(posedge clk);  // gap between reads
        busy  <= 1'b0;
      end
    end
  end
endmodule : host_reader

// File: sim/quad_adc_read_port_test.sv
// Purpose: self-checking bench of the four-channel read port
// Assumes: short idle and oscillator counts
// Notes:   reads are queued notes checked by a watcher
`timescale 1ns/100ps
module quad_adc_read_port_test;
  logic        CLK;
  logic        RST;
  logic        CE;
  logic        CONVERSION_TRIGGER;
  logic        CS_N;
  logic        RD_N;
  logic        CONV_CLK;
  logic [11:0] CH1_SAMPLE;
  logic [11:0] CH2_SAMPLE;
  logic [11:0] CH3_SAMPLE;
  logic [11:0] CH4_SAMPLE;
  logic        INT_N;
  logic        HOLD;
  logic [1:0]  CONV_CH;
  logic [11:0] RESULT_BUS_O;
  logic        RESULT_BUS_OE;
  logic        go;
  logic        sel;
  logic        got_v;
  logic        busy;
  logic        ext_on;
  logic [3:0]  lag;
  logic [12:0] got;
  logic [2:0]  cdiv;
  logic [11:0] smp [4];
  logic [12:0] exp_q [$];
  int          err_total;
  int          num_checks;
  int          k;

  quad_adc_read_port
  #(
    .IDLE_CYC (50),
    .HALF_CYC (2)
  )
  dut
  (
    .CLK, .RST, .CE, .CONVERSION_TRIGGER, .CS_N, .RD_N,
    .CONV_CLK, .CH1_SAMPLE, .CH2_SAMPLE, .CH3_SAMPLE, .CH4_SAMPLE,
    .INT_N, .HOLD, .CONV_CH, .RESULT_BUS_O, .RESULT_BUS_OE
  );

  host_reader host
  (
    .clk (CLK), .go, .sel, .lag, .bus_o (RESULT_BUS_O),
    .bus_oe (RESULT_BUS_OE), .cs_n (CS_N), .rd_n (RD_N), .got, .got_v,
    .busy
  );

  // system clock
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // external conversion clock, 8 CLK period
  always @(posedge CLK)
  begin
    if (RST)
    begin
      cdiv     <= 3'h0;
      CONV_CLK <= 1'b0;
    end
    else
    begin
      cdiv     <= cdiv + 3'h1;
      CONV_CLK <= ext_on & cdiv[2];
    end
  end

  // watcher: oldest note against each result
  always @(posedge CLK)
  begin
    if (got_v === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(got, ~got);  // stray result always counts
      else
        check(got, exp_q.pop_front());
    end
  end

  task automatic check(input logic [12:0] seen, input logic [12:0] want);
    begin
      num_checks++;
      if (seen !== want)
      begin
        err_total++;
        $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask : check

  task automatic give_verdict;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask : give_verdict

  task automatic trig;
    begin
      CONVERSION_TRIGGER <= 1'b1;
      repeat (4) @(posedge CLK);
      CONVERSION_TRIGGER <= 1'b0;
      repeat (4) @(posedge CLK);
    end
  endtask : trig

  // random samples, optional extreme codes, then wait for the flag
  task automatic convert(input logic corner);
    int n;
    begin
      for (n = 0; n < 4; n++)
        smp[n] = 12'($urandom);
      if (corner)
      begin
        smp[0] = 12'h800;
        smp[3] = 12'h7FF;
      end
      CH1_SAMPLE <= smp[0];
      CH2_SAMPLE <= smp[1];
      CH3_SAMPLE <= smp[2];
      CH4_SAMPLE <= smp[3];
      trig();
      for (n = 0; n < 3000 && INT_N !== 1'b0; n++)
        @(posedge CLK);
      check({12'h000, INT_N}, 13'h0000);
      if (INT_N !== 1'b0)
        give_verdict();
    end
  endtask : convert

  task automatic do_read(input logic s, input logic [12:0] want);
    int n;
    begin
      exp_q.push_back(want);
      sel <= s;
      lag <= 4'($urandom_range(3));
      go  <= 1'b1;
      @(posedge CLK);
      go  <= 1'b0;
      @(posedge CLK);
      for (n = 0; n < 60 && busy === 1'b1; n++)
        @(posedge CLK);
      if (busy !== 1'b0)
      begin
        err_total++;
        give_verdict();
      end
    end
  endtask : do_read

  task automatic read_seq(input int first, input int count);
    int i;
    begin
      for (i = 0; i < count; i++)
        do_read(1'b1, {1'b1, smp[(first + i) % 4]});
    end
  endtask : read_seq

  // main sequence
  initial
  begin
    RST = 1'b1;
    CE = 1'b1;
    CONVERSION_TRIGGER = 1'b0;
    CH1_SAMPLE = 12'h000;
    CH2_SAMPLE = 12'h000;
    CH3_SAMPLE = 12'h000;
    CH4_SAMPLE = 12'h000;
    go = 1'b0;
    sel = 1'b1;
    lag = 4'h0;
    ext_on = 1'b1;
    err_total = 0;
    num_checks = 0;
    void'($urandom(61));
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    // order, wrap on the fifth read, stray strobe ignored
    for (k = 0; k < 3; k++)
    begin
      convert(k == 0);
      read_seq(0, 5);
      do_read(1'b0, 13'h0000);
      read_seq(1, 1);
    end
    // new trigger resets the pointer
    convert(1'b0);
    read_seq(0, 1);
    // freeze before the first channel boundary, then restart mid-conversion
    trig();
    repeat (90) @(posedge CLK);
    CE <= 1'b0;
    repeat (100) @(posedge CLK);
    check({10'h000, HOLD, CONV_CH}, 13'h0004);
    CE <= 1'b1;
    repeat (10) @(posedge CLK);
    convert(1'b0);
    read_seq(0, 4);
    // clock pin tied low: internal oscillator
    ext_on <= 1'b0;
    repeat (80) @(posedge CLK);
    convert(1'b0);
    read_seq(0, 4);
    repeat (10) @(posedge CLK);
    check(13'(exp_q.size()), 13'h0000);
    give_verdict();
  end
endmodule : quad_adc_read_port_test
